//--- rtl/vr_seq_pkg.sv
// Constants, types and register map of the regulator sequencer.
// Assumes a single pclk domain; analog comparators arrive as
// synchronous levels.
package vr_seq_pkg;

  localparam int NUM_PHASES = 3;
  localparam int SS_CNT_W   = 11;
  localparam int CODE_W     = 5;

  // Soft-start counts in phase-clock cycles
  localparam logic [SS_CNT_W-1:0] INHIBIT_CYCLES   = 11'h020;
  localparam logic [SS_CNT_W-1:0] CLAMP_CYCLES_DEF = 11'h096;
  localparam logic [SS_CNT_W-1:0] SS_LAST          = 11'h7ff;
  localparam logic [SS_CNT_W-1:0] CNT_ONE          = 11'h001;

  // Voltage code: zero is highest, all ones is off
  localparam logic [CODE_W-1:0] CODE_OFF  = 5'h1f;
  localparam logic [CODE_W-1:0] CODE_STEP = 5'h01;

  // Register byte addresses
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_REF    = 8'h08;
  localparam logic [7:0]  ADDR_SSCNT  = 8'h0c;

  // Field positions
  localparam int ST_GOOD_BIT    = 0;
  localparam int ST_UV_BIT      = 1;
  localparam int ST_OVL_BIT     = 2;
  localparam int ST_OVCLAMP_BIT = 3;
  localparam int ST_STATE_LSB   = 4;
  localparam int REF_CUR_LSB    = 0;
  localparam int REF_TGT_LSB    = 8;

  typedef enum logic [2:0] {
    S_SHUT, S_INHIBIT, S_CLAMP, S_RAMP, S_RUN, S_OVSTOP
  } seq_state_t;

  typedef struct packed {
    logic ov;        // Output above overvoltage limit
    logic at_target; // Output back at the coded level
    logic uv;        // Output below undervoltage threshold
  } sense_t;

  typedef struct packed {
    logic [CODE_W-1:0] seen;
    logic [CODE_W-1:0] target;
    logic [CODE_W-1:0] ref_code;
    logic              half;
  } step_st_t;

  typedef struct packed {
    seq_state_t            st;
    logic [SS_CNT_W-1:0]   cnt;
    logic                  ov_latched;
    logic                  ov_clamp;
    logic                  good;
    logic [NUM_PHASES-1:0] pwm_out;
    logic [NUM_PHASES-1:0] pwm_oe;
    logic                  dac_inhibit;
    logic                  ramp_active;
    logic [SS_CNT_W-1:0]   clamp_len;
    logic [31:0]           prdata;
    logic                  pslverr;
  } seq_st_t;

  localparam seq_st_t SEQ_RST = '{
    st: S_SHUT, cnt: '0, ov_latched: 1'b0, ov_clamp: 1'b0,
    good: 1'b0, pwm_out: '0, pwm_oe: '0, dac_inhibit: 1'b1,
    ramp_active: 1'b0, clamp_len: CLAMP_CYCLES_DEF,
    prdata: '0, pslverr: 1'b0};

endpackage : vr_seq_pkg

//--- rtl/vid_stepper.sv
// Voltage-code tracker that steps the reference one code at a time.
// Assumes cyc_pulse is one pclk wide at each phase-1 cycle start.
`timescale 1ns/100ps

module code_stepper
  import vr_seq_pkg::*;
(
  input  wire logic              pclk,      // Clock
  input  wire logic              presetn,   // Async reset, low
  input  wire logic              cyc_pulse, // Phase-1 cycle start
  input  wire logic              reload,    // Load code directly
  input  wire logic [CODE_W-1:0] code_in,   // Voltage code
  output logic      [CODE_W-1:0] ref_code,  // Stepped reference
  output logic      [CODE_W-1:0] target     // Accepted target
);

  step_st_t s;
  step_st_t next_s;

  function automatic logic [CODE_W-1:0] step_toward(
    input logic [CODE_W-1:0] cur,
    input logic [CODE_W-1:0] dst);
    if (cur < dst) begin
      return cur + CODE_STEP;
    end else if (cur > dst) begin
      return cur - CODE_STEP;
    end
    return cur;
  endfunction : step_toward

  always_comb begin
    next_s = s;
    if (reload) begin
      next_s.seen = code_in;
      next_s.half = 1'b0;
      if (code_in != CODE_OFF) begin
        next_s.target   = code_in;
        next_s.ref_code = code_in;
      end
    end else if (cyc_pulse) begin
      next_s.seen = code_in;
      if (code_in == s.seen && code_in != CODE_OFF &&
          code_in != s.target) begin
        next_s.target = code_in;
        next_s.half   = 1'b0;
      end else if (s.ref_code != s.target) begin
        next_s.half = ~s.half;
        if (s.half) begin
          next_s.ref_code = step_toward(s.ref_code, s.target);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ref_code = s.ref_code;
  assign target   = s.target;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sample_on_pulse;
    !reload && !cyc_pulse |=> $stable(s.seen);
  endproperty
  a_sample_on_pulse: assert property (p_sample_on_pulse)
    else $error("code sampled outside cycle start");

  property p_one_step;
    !$past(reload) && $changed(s.ref_code) |->
      $past(cyc_pulse) && $past(s.half) &&
      (s.ref_code - $past(s.ref_code) == CODE_STEP ||
       $past(s.ref_code) - s.ref_code == CODE_STEP);
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("reference moved other than one step");

endmodule : code_stepper

//--- rtl/vr_enable_softstart_vid_seq.sv
// Enable, soft-start, protection and power-good sequencer of a
// multi-phase buck controller, with an APB register slave.
// Assumes all inputs synchronous to pclk; phase_pulse is one pclk
// wide per phase-1 switching cycle; tri-state resolved outside.
//
// Notes on behaviour
// - Overvoltage drives every phase output low
// - Release phases to hi-Z at target
// - Reclamp each time overvoltage returns
// - Overvoltage stops switching until enable cycled
// - Undervoltage only drops power-good, unlatched
// - Shut-down holds phase outputs hi-Z
// - No start before supply-good report
// - Oscillator runs only while enable high
// - All-ones code shuts down, others start
// - All enables true starts soft-start
// - First 32 cycles inhibit, hi-Z
// - Then hold phases low about 150
// - Then switch, ramp duty from zero
// - Power-good only at 2048th cycle
// - Eleven-bit counter advances per phase pulse
// - Sample code only at cycle start; code loads every pclk in shut-down, and the off code acts on any pclk
// - Stable code: one step per two cycles
// - Code zero highest, all ones off
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps

module vr_enable_softstart_vid_seq
  import vr_seq_pkg::*;
(
  input  wire logic                  pclk,        // 20 MHz clock
  input  wire logic                  presetn,     // Async reset
  input  wire logic                  psel,        // APB select
  input  wire logic                  penable,     // APB enable
  input  wire logic                  pwrite,      // APB write
  input  wire logic [ADDR_W-1:0]     paddr,       // APB address
  input  wire logic [31:0]           pwdata,      // APB write data
  output logic      [31:0]           prdata,      // APB read data
  output logic                       pready,      // APB ready
  output logic                       pslverr,     // APB error
  input  wire logic                  por_ok,      // Supply good
  input  wire logic                  freq_select_enable_input, // Enable
  input  wire logic                  phase_pulse, // Phase-1 start
  input  wire logic [CODE_W-1:0]     voltage_code_bits, // Code
  input  wire sense_t                sense,       // Comparators
  input  wire logic [NUM_PHASES-1:0] pwm_demand,  // Modulator
  output logic      [NUM_PHASES-1:0] pwm_out,     // Phase level
  output logic      [NUM_PHASES-1:0] pwm_oe,      // Phase drive
  output logic                       osc_run,     // Oscillator on
  output logic                       dac_inhibit, // Reference off
  output logic                       ramp_active, // Duty ramp
  output logic      [CODE_W-1:0]     reference_level, // Ref code
  output logic      [CODE_W-1:0]     voltage_id_code, // Target
  output logic                       power_good_flag  // Good
);

  seq_st_t s;
  seq_st_t next_s;

  logic                en_ok;
  logic                run_ok;
  logic                ov_hit;
  logic                cnt_tick;
  logic [SS_CNT_W-1:0] cnt_inc;
  logic [SS_CNT_W-1:0] clamp_end;
  logic                apb_setup;
  logic                apb_write;
  logic                addr_hit;

  // Reference stepping on the phase clock
  code_stepper u_step (
    .pclk      (pclk),
    .presetn   (presetn),
    .cyc_pulse (phase_pulse),
    .reload    (s.st == S_SHUT),
    .code_in   (voltage_code_bits),
    .ref_code  (reference_level),
    .target    (voltage_id_code)
  );

  assign en_ok     = por_ok && freq_select_enable_input;
  assign run_ok    = en_ok && (voltage_code_bits != CODE_OFF);
  assign ov_hit    = en_ok && (sense.ov || s.ov_latched);
  assign cnt_tick  = phase_pulse;
  assign cnt_inc   = s.cnt + CNT_ONE;
  assign clamp_end = INHIBIT_CYCLES + s.clamp_len;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign addr_hit  = (paddr == ADDR_CTRL) ||
                     (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_REF) ||
                     (paddr == ADDR_SSCNT);

  always_comb begin
    next_s = s;

    // Overvoltage latch and clamp tracking
    if (!en_ok) begin
      next_s.ov_latched = 1'b0;
      next_s.ov_clamp   = 1'b0;
    end else begin
      if (sense.ov) begin
        next_s.ov_latched = 1'b1;
        next_s.ov_clamp   = 1'b1;
      end else if (sense.at_target) begin
        next_s.ov_clamp = 1'b0;
      end
    end

    // Sequencer
    if (!en_ok) begin
      next_s.st  = S_SHUT;
      next_s.cnt = '0;
    end else if (ov_hit) begin
      next_s.st  = S_OVSTOP;
      next_s.cnt = '0;
    end else if (!run_ok) begin
      next_s.st  = S_SHUT;
      next_s.cnt = '0;
    end else begin
      unique case (s.st)
        S_SHUT: begin
          next_s.st  = S_INHIBIT;
          next_s.cnt = '0;
        end
        S_INHIBIT: begin
          if (cnt_tick) begin
            next_s.cnt = cnt_inc;
            if (cnt_inc == INHIBIT_CYCLES) begin
              next_s.st = S_CLAMP;
            end
          end
        end
        S_CLAMP: begin
          if (cnt_tick) begin
            next_s.cnt = cnt_inc;
            if (cnt_inc == clamp_end) begin
              next_s.st = S_RAMP;
            end
          end
        end
        S_RAMP: begin
          if (cnt_tick) begin
            if (s.cnt == SS_LAST) begin
              next_s.st = S_RUN;
            end else begin
              next_s.cnt = cnt_inc;
            end
          end
        end
        S_RUN: begin
          next_s.st = S_RUN;
        end
        S_OVSTOP: begin
          next_s.st = S_OVSTOP;
        end
      endcase
    end

    // Phase outputs follow the next state
    unique case (next_s.st)
      S_CLAMP: begin
        next_s.pwm_oe  = '1;
        next_s.pwm_out = '0;
      end
      S_RAMP, S_RUN: begin
        next_s.pwm_oe  = '1;
        next_s.pwm_out = pwm_demand;
      end
      S_OVSTOP: begin
        next_s.pwm_oe  = {NUM_PHASES{next_s.ov_clamp}};
        next_s.pwm_out = '0;
      end
      default: begin
        next_s.pwm_oe  = '0;
        next_s.pwm_out = '0;
      end
    endcase

    next_s.dac_inhibit = (next_s.st == S_SHUT) ||
                         (next_s.st == S_INHIBIT);
    next_s.ramp_active = (next_s.st == S_RAMP);
    next_s.good  = (next_s.st == S_RUN) && !sense.uv;

    // APB registers
    if (apb_write && paddr == ADDR_CTRL) begin
      next_s.clamp_len = pwdata[SS_CNT_W-1:0];
    end
    if (apb_setup) begin
      next_s.pslverr = !addr_hit;
      next_s.prdata  = '0;
      unique case (paddr)
        ADDR_CTRL: begin
          next_s.prdata[SS_CNT_W-1:0] = s.clamp_len;
        end
        ADDR_STATUS: begin
          next_s.prdata[ST_GOOD_BIT]       = s.good;
          next_s.prdata[ST_UV_BIT]         = sense.uv;
          next_s.prdata[ST_OVL_BIT]        = s.ov_latched;
          next_s.prdata[ST_OVCLAMP_BIT]    = s.ov_clamp;
          next_s.prdata[ST_STATE_LSB +: 3] = s.st;
        end
        ADDR_REF: begin
          next_s.prdata[REF_CUR_LSB +: CODE_W] = reference_level;
          next_s.prdata[REF_TGT_LSB +: CODE_W] = voltage_id_code;
        end
        ADDR_SSCNT: begin
          next_s.prdata[SS_CNT_W-1:0] = s.cnt;
        end
        default: begin
          next_s.prdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= SEQ_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pready          = 1'b1;
  assign prdata          = s.prdata;
  assign pslverr         = s.pslverr;
  assign pwm_out         = s.pwm_out;
  assign pwm_oe          = s.pwm_oe;
  assign osc_run         = freq_select_enable_input;
  assign dac_inhibit     = s.dac_inhibit;
  assign ramp_active     = s.ramp_active;
  assign power_good_flag = s.good;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ov_seen;
    en_ok && sense.ov;
  endsequence

  sequence s_clamped;
    pwm_oe == '1 && pwm_out == '0;
  endsequence

  sequence s_back_at_level;
    en_ok && s.st == S_OVSTOP && !sense.ov && sense.at_target;
  endsequence

  property p_ov_clamp;
    s_ov_seen |=> s_clamped;
  endproperty
  a_ov_clamp: assert property (p_ov_clamp)
    else $error("phases not clamped low on overvoltage");

  property p_ov_release;
    s_back_at_level |=> pwm_oe == '0;
  endproperty
  a_ov_release: assert property (p_ov_release)
    else $error("phases not released at coded level");

  property p_ov_repeat;
    s_back_at_level ##1 s_ov_seen |=> s_clamped;
  endproperty
  a_ov_repeat: assert property (p_ov_repeat)
    else $error("returning overvoltage not clamped again");

  property p_ov_stop;
    s.ov_latched && en_ok |=> s.st == S_OVSTOP && !power_good_flag;
  endproperty
  a_ov_stop: assert property (p_ov_stop)
    else $error("switching resumed without enable cycle");

  property p_uv_power_good_flag;
    sense.uv |=> !power_good_flag;
  endproperty
  a_uv_power_good_flag: assert property (p_uv_power_good_flag)
    else $error("power good high during undervoltage");

  property p_uv_unlatched;
    s.st == S_RUN && run_ok && !sense.ov && !sense.uv
      |=> power_good_flag;
  endproperty
  a_uv_unlatched: assert property (p_uv_unlatched)
    else $error("power good held low after undervoltage");

  property p_shut_hiz;
    s.st == S_SHUT |-> pwm_oe == '0;
  endproperty
  a_shut_hiz: assert property (p_shut_hiz)
    else $error("phase driven during shut-down");

  property p_por_hold;
    !por_ok |=> s.st == S_SHUT && dac_inhibit;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("started without supply good");

  property p_start;
    s.st == S_SHUT && run_ok && !sense.ov && !s.ov_latched
      |=> s.st == S_INHIBIT && s.cnt == '0;
  endproperty
  a_start: assert property (p_start)
    else $error("soft-start not begun with enables true");

  property p_code_off;
    en_ok && !ov_hit && voltage_code_bits == CODE_OFF
      |=> s.st == S_SHUT;
  endproperty
  a_code_off: assert property (p_code_off)
    else $error("off code did not shut down");

  property p_inhibit;
    s.st == S_INHIBIT |-> pwm_oe == '0 && dac_inhibit &&
                          s.cnt < INHIBIT_CYCLES;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit interval broken");

  property p_clamp_low;
    s.st == S_CLAMP |-> s_clamped and s.cnt >= INHIBIT_CYCLES;
  endproperty
  a_clamp_low: assert property (p_clamp_low)
    else $error("low clamp interval broken");

  property p_power_good_flag_late;
    $rose(power_good_flag) |-> s.cnt == SS_LAST &&
                              $past(s.st) inside {S_RAMP, S_RUN};
  endproperty
  a_power_good_flag_late: assert property (p_power_good_flag_late)
    else $error("power good before final soft-start cycle");

  property p_cnt_tick;
    s.st inside {S_INHIBIT, S_CLAMP, S_RAMP} && !phase_pulse
      ##1 s.st inside {S_INHIBIT, S_CLAMP, S_RAMP} |-> $stable(s.cnt);
  endproperty
  a_cnt_tick: assert property (p_cnt_tick)
    else $error("counter moved without phase pulse");

  property p_lost_enable;
    !en_ok |=> s.st == S_SHUT && s.cnt == '0 && pwm_oe == '0;
  endproperty
  a_lost_enable: assert property (p_lost_enable)
    else $error("lost enable did not return to shut-down");

endmodule : vr_enable_softstart_vid_seq

//--- tb/vr_phase_clock_model.sv
// Far-side model: oscillator and phase-1 pulse source.
// Assumes pclk from the bench; one pulse every PER pclk cycles.
`timescale 1ns/100ps

module vr_phase_clock_model #(
  parameter int PER = 5
) (
  input  wire logic pclk,        // Clock
  input  wire logic presetn,     // Reset, low
  input  wire logic osc_run,     // Oscillator on
  output logic      phase_pulse  // Phase-1 start
);
  logic [7:0] div;

  // Pulses stand still while the oscillator is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div         <= 8'h00;
      phase_pulse <= 1'b0;
    end else if (!osc_run) begin
      div         <= 8'h00;
      phase_pulse <= 1'b0;
    end else begin
      div         <= (div == 8'(PER - 1)) ? 8'h00 : div + 8'h01;
      phase_pulse <= (div == 8'(PER - 1));
    end
  end
endmodule : vr_phase_clock_model

//--- tb/tb_vr_enable_softstart_vid_seq.sv
// Bench for the regulator sequencer: APB tasks and pin scenarios.
// Assumes the phase clock model paces soft-start at 5 pclk a pulse.
`timescale 1ns/100ps

module tb_vr_enable_softstart_vid_seq;
  import vr_seq_pkg::*;

  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [ADDR_W-1:0]     paddr = '0;
  logic [31:0]           pwdata = '0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  por_ok = 1'b0;
  logic                  freq_select_enable_input = 1'b0;
  logic                  phase_pulse;
  logic [CODE_W-1:0]     voltage_code_bits = 5'h10;
  sense_t                sense = '0;
  logic [NUM_PHASES-1:0] pwm_demand = 3'h5;
  logic [NUM_PHASES-1:0] pwm_out;
  logic [NUM_PHASES-1:0] pwm_oe;
  logic                  osc_run;
  logic                  dac_inhibit;
  logic                  ramp_active;
  logic [CODE_W-1:0]     reference_level;
  logic [CODE_W-1:0]     voltage_id_code;
  logic                  power_good_flag;
  int                    fail_count = 0;
  int                    tests_run = 0;

  always #25 pclk = ~pclk;

  vr_enable_softstart_vid_seq dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .por_ok, .freq_select_enable_input,
    .phase_pulse, .voltage_code_bits, .sense, .pwm_demand, .pwm_out,
    .pwm_oe, .osc_run, .dac_inhibit, .ramp_active, .reference_level,
    .voltage_id_code, .power_good_flag
  );

  vr_phase_clock_model #(.PER(5)) far (
    .pclk, .presetn, .osc_run, .phase_pulse
  );

  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Count n phase pulses, then settle two edges
  task automatic pulses(input int n);
    int k;
    int t;
    k = 0;
    for (t = 0; t < n * 8 + 20 && k < n; t++) begin
      @(posedge pclk);
      if (phase_pulse === 1'b1) begin
        k++;
      end
    end
    if (k < n) begin
      fail_count++;
      summarize();
    end
    repeat (2) @(posedge pclk);
    #1;
  endtask : pulses

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (t == 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask : rdchk

  task automatic ph(input logic [2:0] oe, input logic [2:0] out);
    chk({pwm_oe, pwm_out}, {oe, out});
  endtask : ph

  initial begin
    logic [31:0] rd;
    logic        er;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pulses(0);
    chk(osc_run, 1'b0);
    ph(3'h0, 3'h0);
    chk(dac_inhibit, 1'b1);
    rdchk(ADDR_CTRL, 32'h096, 1'b0);
    rdchk(8'h10, 32'h0, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h00a, rd, er);
    rdchk(ADDR_CTRL, 32'h00a, 1'b0);
    @(posedge pclk);
    freq_select_enable_input <= 1'b1;
    pulses(40);
    chk(osc_run, 1'b1);
    chk({pwm_oe, dac_inhibit}, 4'h1);
    @(posedge pclk);
    por_ok <= 1'b1;
    pulses(31);
    chk({pwm_oe, dac_inhibit}, 4'h1);
    pulses(1);
    ph(3'h7, 3'h0);
    chk(dac_inhibit, 1'b0);
    pulses(9);
    ph(3'h7, 3'h0);
    chk(ramp_active, 1'b0);
    pulses(1);
    chk(ramp_active, 1'b1);
    ph(3'h7, 3'h5);
    pulses(2005);
    chk(power_good_flag, 1'b0);
    pulses(1);
    chk({power_good_flag, ramp_active}, 2'h2);
    chk(reference_level, 5'h10);
    rdchk(ADDR_STATUS, 32'h41, 1'b0);
    @(posedge pclk);
    sense <= 3'h1;
    pulses(0);
    chk(power_good_flag, 1'b0);
    ph(3'h7, 3'h5);
    @(posedge pclk);
    sense <= 3'h0;
    pulses(0);
    chk(power_good_flag, 1'b1);
    @(posedge pclk);
    voltage_code_bits <= 5'h12;
    pulses(1);
    chk(reference_level, 5'h10);
    pulses(8);
    chk({voltage_id_code, reference_level}, 10'h252);
    @(posedge pclk);
    voltage_code_bits <= 5'h0e;
    pulses(5);
    @(posedge pclk);
    voltage_code_bits <= 5'h0f;
    pulses(16);
    chk({voltage_id_code, reference_level}, 10'h1ef);
    rdchk(ADDR_REF, 32'h0f0f, 1'b0);
    @(posedge pclk);
    sense <= 3'h4;
    pulses(0);
    ph(3'h7, 3'h0);
    @(posedge pclk);
    sense <= 3'h2;
    pulses(0);
    ph(3'h0, 3'h0);
    @(posedge pclk);
    sense <= 3'h4;
    pulses(0);
    ph(3'h7, 3'h0);
    @(posedge pclk);
    sense <= 3'h2;
    pulses(10);
    ph(3'h0, 3'h0);
    rdchk(ADDR_STATUS, 32'h54, 1'b0);
    @(posedge pclk);
    sense <= 3'h0;
    freq_select_enable_input <= 1'b0;
    pulses(0);
    chk(osc_run, 1'b0);
    @(posedge pclk);
    freq_select_enable_input <= 1'b1;
    voltage_code_bits <= 5'h1f;
    pulses(40);
    ph(3'h0, 3'h0);
    rdchk(ADDR_STATUS, 32'h0, 1'b0);
    @(posedge pclk);
    voltage_code_bits <= 5'h10;
    pulses(32);
    ph(3'h7, 3'h0);
    @(posedge pclk);
    freq_select_enable_input <= 1'b0;
    pulses(0);
    ph(3'h0, 3'h0);
    rdchk(ADDR_SSCNT, 32'h0, 1'b0);
    summarize();
  end
endmodule : tb_vr_enable_softstart_vid_seq
